/* File: verilog/accel_out_pkg.sv */
package accel_out_pkg;
  // sample geometry
  localparam int AXIS_W = 12;
  localparam int BYTE_W = 8;
  localparam int NIBBLE_W = 4;
  localparam int ADDR_W = 8;
  localparam int SIGN_BIT = 11;
  localparam int SAMPLE_W = 4 * AXIS_W;
  // field positions of one packed sample word: temp, x, y, z from the top
  localparam int TEMP_POS = 3 * AXIS_W;
  localparam int X_POS = 2 * AXIS_W;
  localparam int Y_POS = AXIS_W;
  localparam int Z_POS = 0;
  localparam int FIFO_DEPTH = 16;
  // output register offsets
  localparam logic [ADDR_W-1:0] X_LOW_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] X_HIGH_OFS = 8'h05;
  localparam logic [ADDR_W-1:0] Y_LOW_OFS = 8'h06;
  localparam logic [ADDR_W-1:0] Y_HIGH_OFS = 8'h07;
  localparam logic [ADDR_W-1:0] Z_LOW_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] Z_HIGH_OFS = 8'h09;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h01;
  localparam logic [ADDR_W-1:0] FAST_STEP = 8'h02;
  localparam logic [BYTE_W-1:0] UNMAPPED_DATA = 8'h00;
  // spacing between conversions
  localparam int CONV_GAP_US = 40;
  localparam int CLK_FREQ_MHZ = 125;
  localparam int CONV_GAP_CYC = CONV_GAP_US * CLK_FREQ_MHZ;
  typedef enum logic [1:0] {CH_TEMP, CH_X, CH_Y, CH_Z} adc_chan_e;
endpackage

/* File: verilog/sample_stream_if.sv */
`timescale 1ns/10ps
interface sample_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: verilog/sample_fifo.sv */
`timescale 1ns/10ps
module sample_fifo
  import accel_out_pkg::*;
#(
  parameter int WIDTH = SAMPLE_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rstn,
  sample_stream_if.snk in_s,
  sample_stream_if.src out_s
);
  // depth must be a power of two so that the pointers wrap by themselves
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_CNT = DEPTH[PTR_W:0];
  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
  } fifo_state_s;
  fifo_state_s st_ff;
  fifo_state_s nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // handshakes straight from the occupancy count
  assign in_s.ready = (st_ff.count != FULL_CNT);
  assign out_s.valid = (st_ff.count != '0);
  assign out_s.data = mem[st_ff.rd_ptr];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  // pointer and count update
  always_comb begin
    nxt_st = st_ff;
    if (push) nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
    if (pop) nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
    if (push && !pop) nxt_st.count = st_ff.count + 1'b1;
    else if (pop && !push) nxt_st.count = st_ff.count - 1'b1;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  // storage needs no reset, the count guards it
  always_ff @(posedge core_clk) begin
    if (push) mem[st_ff.wr_ptr] <= in_s.data;
  end
endmodule

/* File: verilog/conv_sequencer.sv */
`timescale 1ns/10ps
module conv_sequencer
  import accel_out_pkg::*;
#(
  parameter int GAP_CYC = CONV_GAP_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic conv_start,
  input wire logic adc_done,
  input wire logic [AXIS_W-1:0] adc_result,
  output logic adc_go,
  output adc_chan_e adc_chan,
  sample_stream_if.src out_s
);
  localparam int CNT_W = $clog2(GAP_CYC + 1);
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_CONVERT, SEQ_GAP, SEQ_PUSH} seq_state_e;
  typedef struct packed {
    seq_state_e state;
    adc_chan_e chan;
    logic go;
    logic [CNT_W-1:0] cnt;
    logic [AXIS_W-1:0] temp;
    logic [AXIS_W-1:0] x;
    logic [AXIS_W-1:0] y;
    logic [AXIS_W-1:0] z;
  } seq_state_s;
  seq_state_s st_ff;
  seq_state_s nxt_st;

  assign adc_go = st_ff.go;
  assign adc_chan = st_ff.chan;
  assign out_s.valid = (st_ff.state == SEQ_PUSH);
  assign out_s.data = {st_ff.temp, st_ff.x, st_ff.y, st_ff.z};

  // temp, x, y, z in turn; a frame only starts when the fifo has room
  always_comb begin
    nxt_st = st_ff;
    nxt_st.go = 1'b0;
    unique case (st_ff.state)
      SEQ_IDLE: if (conv_start && out_s.ready) begin
        nxt_st.state = SEQ_CONVERT;
        nxt_st.chan = CH_TEMP;
        nxt_st.go = 1'b1;
      end
      SEQ_CONVERT: if (adc_done) begin
        unique case (st_ff.chan)
          CH_TEMP: nxt_st.temp = adc_result;
          CH_X: nxt_st.x = adc_result;
          CH_Y: nxt_st.y = adc_result;
          CH_Z: nxt_st.z = adc_result;
        endcase
        nxt_st.state = (st_ff.chan == CH_Z) ? SEQ_PUSH : SEQ_GAP;
        nxt_st.cnt = CNT_W'(GAP_CYC - 1);
      end
      SEQ_GAP: if (st_ff.cnt == '0) begin
        if (st_ff.chan == CH_TEMP) nxt_st.chan = CH_X;
        else if (st_ff.chan == CH_X) nxt_st.chan = CH_Y;
        else nxt_st.chan = CH_Z;
        nxt_st.go = 1'b1;
        nxt_st.state = SEQ_CONVERT;
      end else begin
        nxt_st.cnt = st_ff.cnt - 1'b1;
      end
      SEQ_PUSH: if (out_s.ready) nxt_st.state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) st_ff <= '{state: SEQ_IDLE, chan: CH_TEMP, default: '0};
    else st_ff <= nxt_st;
  end

  // cycles since the last finished conversion, read only by the checks
  int since_done_ff;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) since_done_ff <= 0;
    else if (adc_done) since_done_ff <= 0;
    else since_done_ff <= since_done_ff + 1;
  end

  sequence s_z_done;
    st_ff.state == SEQ_CONVERT && adc_done && st_ff.chan == CH_Z;
  endsequence
  chk_conv_gap: assert property (@(posedge core_clk) disable iff (!rstn)
    adc_go && adc_chan != CH_TEMP |-> since_done_ff == GAP_CYC)
    else $error("conversion spacing wrong");
  chk_conv_order: assert property (@(posedge core_clk) disable iff (!rstn)
    adc_go && adc_chan == CH_X |-> $past(adc_chan) == CH_TEMP)
    else $error("x converted out of order");
  chk_push_after_z: assert property (@(posedge core_clk) disable iff (!rstn)
    s_z_done |=> out_s.valid)
    else $error("sample not offered after z");
endmodule

/* File: verilog/accel_output_data_regs.sv */
`timescale 1ns/10ps
module accel_output_data_regs
  import accel_out_pkg::*;
#(
  parameter int GAP_CYC = CONV_GAP_CYC,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic conv_start,
  input wire logic adc_done,
  input wire logic [AXIS_W-1:0] adc_result,
  output logic adc_go,
  output adc_chan_e adc_chan,
  input wire logic byte_order_select,
  input wire logic fast_read_enable,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic xfer_end,
  output logic [BYTE_W-1:0] rd_data,
  output logic rd_valid,
  output logic rd_hit,
  output logic [ADDR_W-1:0] next_addr,
  output logic data_ready_event_flag,
  output logic [AXIS_W-1:0] temp_value
);
  typedef struct packed {
    logic [AXIS_W-1:0] temp;
    logic [AXIS_W-1:0] x;
    logic [AXIS_W-1:0] y;
    logic [AXIS_W-1:0] z;
    logic drdy;
    logic be;
    logic burst;
    logic rd_valid;
    logic rd_hit;
    logic [BYTE_W-1:0] rd_data;
    logic [ADDR_W-1:0] next_addr;
  } out_state_s;
  out_state_s st_ff;
  out_state_s nxt_st;

  sample_stream_if #(.W(SAMPLE_W)) conv_s ();
  sample_stream_if #(.W(SAMPLE_W)) fifo_s ();

  // acquisition side: fills the fifo, stalls when it is full
  conv_sequencer #(.GAP_CYC(GAP_CYC)) u_seq (
    .core_clk(core_clk),
    .rstn(rstn),
    .conv_start(conv_start),
    .adc_done(adc_done),
    .adc_result(adc_result),
    .adc_go(adc_go),
    .adc_chan(adc_chan),
    .out_s(conv_s.src)
  );

  // decouples conversion pace from how often the host reads
  sample_fifo #(.WIDTH(SAMPLE_W), .DEPTH(DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_s(conv_s.snk),
    .out_s(fifo_s.src)
  );

  // no new sample lands after a burst's first read until it ends, so only its first byte can come from an older sample
  assign fifo_s.ready = !st_ff.burst;

  logic pop;
  logic [AXIS_W-1:0] pop_x;
  logic [AXIS_W-1:0] pop_y;
  logic [AXIS_W-1:0] pop_z;
  assign pop = fifo_s.valid & fifo_s.ready;
  assign pop_x = fifo_s.data[X_POS +: AXIS_W];
  assign pop_y = fifo_s.data[Y_POS +: AXIS_W];
  assign pop_z = fifo_s.data[Z_POS +: AXIS_W];

  // one byte of an axis in the layout chosen by byte order and fast read
  function automatic logic [BYTE_W-1:0] format_byte(
    input logic [AXIS_W-1:0] v,
    input logic high,
    input logic msb_first
  );
    if (msb_first) begin
      if (high) return {v[NIBBLE_W-1:0], {NIBBLE_W{1'b0}}};
      else return v[AXIS_W-1 -: BYTE_W];
    end else begin
      if (high) return {{NIBBLE_W{v[SIGN_BIT]}}, v[SIGN_BIT -: NIBBLE_W]};
      else return v[BYTE_W-1:0];
    end
  endfunction

  // address decode of the output window
  logic sel_hit;
  logic sel_high;
  logic sel_low;
  logic [AXIS_W-1:0] sel_axis;
  always_comb begin
    sel_hit = 1'b1;
    sel_high = 1'b0;
    sel_axis = st_ff.x;
    unique case (rd_addr)
      X_LOW_OFS: sel_axis = st_ff.x;
      X_HIGH_OFS: begin
        sel_axis = st_ff.x;
        sel_high = 1'b1;
      end
      Y_LOW_OFS: sel_axis = st_ff.y;
      Y_HIGH_OFS: begin
        sel_axis = st_ff.y;
        sel_high = 1'b1;
      end
      Z_LOW_OFS: sel_axis = st_ff.z;
      Z_HIGH_OFS: begin
        sel_axis = st_ff.z;
        sel_high = 1'b1;
      end
      default: sel_hit = 1'b0;
    endcase
  end
  assign sel_low = sel_hit & !sel_high;

  // latch, read answer, flag and burst bookkeeping
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd_valid = rd_en;
    // config taken through a flop so reset gives little-endian
    nxt_st.be = byte_order_select;
    if (rd_en) begin
      nxt_st.rd_hit = sel_hit;
      nxt_st.rd_data = sel_hit
        ? format_byte(sel_axis, sel_high, st_ff.be | fast_read_enable)
        : UNMAPPED_DATA;
      // fast read hops over the high bytes, other reads step by one
      if (fast_read_enable && sel_low) nxt_st.next_addr = rd_addr + FAST_STEP;
      else nxt_st.next_addr = rd_addr + ADDR_STEP;
      if (sel_hit) nxt_st.drdy = 1'b0;
    end
    // a frame's end wins over its own first byte, so single reads leave no burst
    nxt_st.burst = (st_ff.burst | rd_en) & !xfer_end;
    // set after clear: a sample landing with a read is not lost
    if (pop) begin
      nxt_st.temp = fifo_s.data[TEMP_POS +: AXIS_W];
      nxt_st.x = pop_x;
      nxt_st.y = pop_y;
      nxt_st.z = pop_z;
      nxt_st.drdy = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  assign rd_data = st_ff.rd_data;
  assign rd_valid = st_ff.rd_valid;
  assign rd_hit = st_ff.rd_hit;
  assign next_addr = st_ff.next_addr;
  assign data_ready_event_flag = st_ff.drdy;
  assign temp_value = st_ff.temp;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_pop;
    pop;
  endsequence
  sequence s_read_clear;
    rd_en && sel_hit && !pop;
  endsequence
  sequence s_le_read(logic [ADDR_W-1:0] a);
    rd_en && !fast_read_enable && !st_ff.be && rd_addr == a;
  endsequence
  sequence s_fast_first;
    rd_en && fast_read_enable && rd_addr == X_LOW_OFS;
  endsequence

  chk_latch_sets_flag: assert property (
    s_pop |=> data_ready_event_flag && st_ff.x == $past(pop_x) && st_ff.z == $past(pop_z))
    else $error("axes not latched with flag");
  chk_read_clears_flag: assert property (
    s_read_clear |=> !data_ready_event_flag)
    else $error("flag not cleared by read");
  chk_reset_little: assert property (
    $rose(rstn) |-> !st_ff.be)
    else $error("byte order not little after reset");
  chk_fast_skip: assert property (
    s_fast_first ##1 (rd_en && fast_read_enable && rd_addr == next_addr)
    |=> next_addr == Z_LOW_OFS)
    else $error("fast burst did not skip high bytes");
  chk_fast_step: assert property (
    rd_en && fast_read_enable && sel_low |=> next_addr == $past(rd_addr) + FAST_STEP)
    else $error("fast step not two");
  chk_plain_step: assert property (
    rd_en && !fast_read_enable |=> next_addr == $past(rd_addr) + ADDR_STEP)
    else $error("plain step not one");
  chk_le_low: assert property (
    s_le_read(X_LOW_OFS) |=> rd_valid && rd_data == $past(st_ff.x[BYTE_W-1:0]))
    else $error("little-endian low byte wrong");
  chk_le_sign: assert property (
    s_le_read(Y_HIGH_OFS) |=> rd_data[BYTE_W-1:NIBBLE_W] == {NIBBLE_W{$past(st_ff.y[SIGN_BIT])}})
    else $error("sign fill bits wrong");
  chk_be_high: assert property (
    rd_en && st_ff.be && rd_addr == Z_HIGH_OFS
    |=> rd_data == {$past(st_ff.z[NIBBLE_W-1:0]), {NIBBLE_W{1'b0}}})
    else $error("big-endian low nibble wrong");
  chk_fast_msb: assert property (
    rd_en && fast_read_enable && rd_addr == Y_LOW_OFS
    |=> rd_data == $past(st_ff.y[AXIS_W-1 -: BYTE_W]))
    else $error("fast read msb not at low address");
  chk_unmapped_zero: assert property (
    rd_en && !sel_hit |=> rd_data == UNMAPPED_DATA && !rd_hit)
    else $error("unmapped read not zero");
endmodule

/* File: tb/adc_model.sv */
`timescale 1ns/10ps
module adc_model
  import accel_out_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic adc_go,
  input wire logic [1:0] adc_chan,
  input wire logic [SAMPLE_W-1:0] word,
  input wire logic [7:0] lat,
  output logic adc_done,
  output logic [AXIS_W-1:0] adc_result
);
  logic [7:0] cnt_ff;
  logic [1:0] chan_ff;
  // converts the requested channel after lat cycles, prompt or slow
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 8'h00;
      chan_ff <= 2'h0;
      adc_done <= 1'b0;
      adc_result <= 12'h000;
    end else begin
      adc_done <= 1'b0;
      adc_result <= ~adc_result; // no hold outside the done pulse
      if (adc_go) begin
        cnt_ff <= lat;
        chan_ff <= adc_chan;
      end else if (cnt_ff == 8'h01) begin
        cnt_ff <= 8'h00;
        adc_done <= 1'b1;
        adc_result <= word[(3 - chan_ff) * AXIS_W +: AXIS_W];
      end else if (cnt_ff != 8'h00) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end
endmodule

/* File: tb/accel_output_data_regs_tb.sv */
`timescale 1ns/10ps
module accel_output_data_regs_tb
  import accel_out_pkg::*;
;
  localparam int GAP = 4;
  typedef struct {
    logic [SAMPLE_W-1:0] w;
    logic be;
    logic fast;
    logic [ADDR_W-1:0] start;
    logic [7:0] lat;
    logic [BYTE_W-1:0] first;
  } row_s;
  logic core_clk, rstn, conv_start, byte_order_select, fast_read_enable, rd_en, xfer_end;
  logic adc_done, adc_go, rd_valid, rd_hit, data_ready_event_flag;
  logic [ADDR_W-1:0] rd_addr, next_addr;
  logic [AXIS_W-1:0] adc_result, temp_value;
  logic [BYTE_W-1:0] rd_data, got_first;
  logic [SAMPLE_W-1:0] word;
  logic [7:0] lat;
  logic [AXIS_W-1:0] ax [3];
  logic [1:0] want_chan = 2'h0;
  adc_chan_e adc_chan;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  int done_at = 0;
  // temp, x, y, z; byte order; fast read; burst start; adc latency; first byte
  row_s rows [9] = '{
    '{{12'h001, 12'h8a5, 12'h3c7, 12'hf01}, 1'b0, 1'b0, 8'h04, 8'h01, 8'ha5},
    '{{12'h002, 12'h7f3, 12'h800, 12'h0ff}, 1'b1, 1'b0, 8'h04, 8'h14, 8'h7f},
    '{{12'h003, 12'h123, 12'h9ab, 12'h456}, 1'b0, 1'b1, 8'h04, 8'h01, 8'h12},
    '{{12'h004, 12'hfed, 12'h0cb, 12'ha98}, 1'b1, 1'b1, 8'h04, 8'h03, 8'hfe},
    '{{12'h005, 12'h654, 12'hc21, 12'h0e0}, 1'b0, 1'b0, 8'h05, 8'h01, 8'h06},
    '{{12'h006, 12'h000, 12'hfff, 12'h7ff}, 1'b0, 1'b0, 8'h07, 8'h02, 8'hff},
    '{{12'h007, 12'habc, 12'hdef, 12'h801}, 1'b1, 1'b0, 8'h09, 8'h01, 8'h10},
    '{{12'h008, 12'h111, 12'h222, 12'h8f3}, 1'b0, 1'b0, 8'h08, 8'h01, 8'hf3},
    '{{12'h009, 12'h333, 12'h444, 12'h555}, 1'b1, 1'b0, 8'h06, 8'h01, 8'h44}};

  accel_output_data_regs #(.GAP_CYC(GAP), .DEPTH(FIFO_DEPTH)) i_dut (
    .core_clk(core_clk), .rstn(rstn), .conv_start(conv_start), .adc_done(adc_done),
    .adc_result(adc_result), .adc_go(adc_go), .adc_chan(adc_chan),
    .byte_order_select(byte_order_select), .fast_read_enable(fast_read_enable),
    .rd_en(rd_en), .rd_addr(rd_addr), .xfer_end(xfer_end), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_hit(rd_hit), .next_addr(next_addr),
    .data_ready_event_flag(data_ready_event_flag), .temp_value(temp_value));
  adc_model i_adc (
    .core_clk(core_clk), .rstn(rstn), .adc_go(adc_go), .adc_chan(adc_chan),
    .word(word), .lat(lat), .adc_done(adc_done), .adc_result(adc_result));

  // 125 MHz
  always #4 core_clk = ~core_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic conclude;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a);
    if (fast_read_enable && (a == 8'h04 || a == 8'h06 || a == 8'h08))
      return a + 8'h02;
    return a + 8'h01;
  endfunction

  // expected byte from the latched axes and the current mode
  function automatic logic [BYTE_W-1:0] exp_byte(input logic [ADDR_W-1:0] a);
    logic [AXIS_W-1:0] v;
    if (a < 8'h04 || a > 8'h09)
      return 8'h00;
    v = ax[(a - 8'h04) >> 1];
    if (fast_read_enable || byte_order_select)
      return a[0] ? {v[3:0], 4'h0} : v[11:4];
    return a[0] ? {{4{v[11]}}, v[11:8]} : v[7:0];
  endfunction

  // back-to-back reads: drive at the rising edge, judge at the falling edge
  task automatic burst(input logic [ADDR_W-1:0] a, input int n);
    logic [ADDR_W-1:0] cur;
    cur = a;
    @(posedge core_clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    xfer_end <= (n == 1);
    for (int i = 1; i <= n; i++) begin
      @(posedge core_clk);
      rd_en <= (i < n);
      xfer_end <= (i == n - 1);
      rd_addr <= step(cur);
      @(negedge core_clk);
      if (i == 1)
        got_first = rd_data;
      check(rd_valid, 1'b1);
      check(rd_data, exp_byte(cur));
      check(rd_hit, cur >= 8'h04 && cur <= 8'h09);
      check(next_addr, step(cur));
      cur = step(cur);
    end
  endtask

  task automatic frame(input logic [SAMPLE_W-1:0] w, input logic took, input logic shown);
    int n;
    n = 0;
    @(posedge core_clk);
    word <= w;
    conv_start <= 1'b1;
    @(posedge core_clk);
    conv_start <= 1'b0;
    @(negedge core_clk);
    check(adc_go, took);
    while (took && n < 500 && !(adc_done === 1'b1 && adc_chan === CH_Z)) begin
      @(negedge core_clk);
      n++;
    end
    if (took) begin
      repeat (6) @(negedge core_clk);
      ax[0] = w[X_POS +: AXIS_W];
      ax[1] = w[Y_POS +: AXIS_W];
      ax[2] = w[Z_POS +: AXIS_W];
    end
    if (shown) begin
      check(data_ready_event_flag, 1'b1);
      check(temp_value, w[TEMP_POS +: AXIS_W]);
    end
  endtask

  // channel order and the gap from each done to the next start in the same frame
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (adc_done === 1'b1)
      done_at <= cyc;
    if (adc_go === 1'b1) begin
      check(adc_chan, want_chan);
      if (want_chan != 2'h0)
        check(16'(cyc - done_at), 16'(GAP + 1));
      want_chan <= want_chan + 2'h1;
    end
  end

  // watchdog, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    conclude();
  end

  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    conv_start = 1'b0;
    byte_order_select = 1'b0;
    fast_read_enable = 1'b0;
    rd_en = 1'b0;
    rd_addr = 8'h00;
    xfer_end = 1'b0;
    word = '0;
    lat = 8'h01;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    check(data_ready_event_flag, 1'b0);
    check(rd_valid, 1'b0);
    check(adc_chan, CH_TEMP);
    $display("test reset done");
    foreach (rows[k]) begin
      @(posedge core_clk);
      lat <= rows[k].lat;
      byte_order_select <= rows[k].be;
      fast_read_enable <= rows[k].fast;
      frame(rows[k].w, 1'b1, 1'b1);
      burst(rows[k].start, rows[k].fast ? 3 : 10 - rows[k].start);
      check(got_first, rows[k].first);
      check(data_ready_event_flag, 1'b0);
      $display("test row %0d done", k);
    end
    // unmapped reads leave the flag alone
    frame(rows[0].w, 1'b1, 1'b1);
    burst(8'h03, 1);
    burst(8'h0a, 1);
    check(data_ready_event_flag, 1'b1);
    $display("test unmapped done");
    // hold a burst open so samples pile up until the buffer refuses
    @(posedge core_clk);
    rd_en <= 1'b1;
    rd_addr <= X_LOW_OFS;
    @(posedge core_clk);
    rd_en <= 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++)
      frame({4{12'(i + 16)}}, 1'b1, 1'b0);
    frame({4{12'hfff}}, 1'b0, 1'b0);
    check(data_ready_event_flag, 1'b0);
    @(posedge core_clk);
    xfer_end <= 1'b1;
    @(posedge core_clk);
    xfer_end <= 1'b0;
    repeat (24) @(negedge core_clk);
    check(data_ready_event_flag, 1'b1);
    burst(X_LOW_OFS, 6);
    frame(rows[1].w, 1'b1, 1'b1);
    $display("test buffer done");
    conclude();
  end
endmodule
